//--- repeater_cfg_pkg.sv
`default_nettype none
package repeater_cfg_pkg;
    // lane counts, side A lanes first, then side B
    localparam int NUM_LANES = 8;
    localparam int LANES_PER_SIDE = 4;
    // resolved four-level pin codes, in ascending voltage order
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_R = 2'h1;
    localparam logic [1:0] LVL_FLOAT = 2'h2;
    localparam logic [1:0] LVL_1 = 2'h3;
    // output swing codes, 0.8 V to 1.3 V in 0.1 V steps
    localparam logic [2:0] SWING_0P8 = 3'h0;
    localparam logic [2:0] SWING_0P9 = 3'h1;
    localparam logic [2:0] SWING_1P0 = 3'h2;
    localparam logic [2:0] SWING_1P1 = 3'h3;
    localparam logic [2:0] SWING_1P2 = 3'h4;
    localparam logic [2:0] SWING_1P3 = 3'h5;
    // de-emphasis codes: 0, -3.5, -6, -9 dB
    localparam logic [1:0] DEEMPH_0DB = 2'h0;
    localparam logic [1:0] DEEMPH_3P5DB = 2'h1;
    localparam logic [1:0] DEEMPH_6DB = 2'h2;
    localparam logic [1:0] DEEMPH_9DB = 2'h3;
    // idle detect threshold register codes
    localparam logic [1:0] THR_CODE_LVL0 = 2'h2;
    localparam logic [1:0] THR_CODE_LVLR = 2'h1;
    localparam logic [1:0] THR_CODE_FLOAT = 2'h0;
    localparam logic [1:0] THR_CODE_LVL1 = 2'h3;
    // configuration source, one-hot
    typedef enum logic [2:0] {
        MODE_PIN = 3'b001,
        MODE_SLAVE = 3'b010,
        MODE_MASTER = 3'b100
    } mode_e;
    // per-lane settings, also the low bits of each lane register
    typedef struct packed {
        logic term_dis;
        logic [1:0] deemph;
        logic [2:0] swing;
        logic [7:0] eq;
    } lane_cfg_s;
    // one pair of four-level selector pins
    typedef struct packed {
        logic [1:0] high;
        logic [1:0] low;
    } pin_pair_s;
    // all selector pins of both sides
    typedef struct packed {
        pin_pair_s eq_a;
        pin_pair_s eq_b;
        pin_pair_s dem_a;
        pin_pair_s dem_b;
    } pin_group_s;
    // register map, byte addresses
    localparam logic [11:0] LANE_BASE_OFS = 12'h000;
    localparam logic [11:0] CTRL_OFS = 12'h020;
    localparam logic [11:0] STATUS_OFS = 12'h024;
    // field positions
    localparam int CTRL_THR_LSB = 0;
    localparam int CTRL_OVR_BIT = 8;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_THR_LSB = 4;
    localparam int STAT_ADDR_LSB = 8;
    localparam int STAT_READY_BIT = 12;
    // reset values
    localparam logic [13:0] LANE_CFG_RST = 14'h0200;
    localparam logic [1:0] THR_RST = 2'h0;
    // power-on settle limit
    localparam int POR_TIME_MS = 500;
    localparam int CLK_MHZ = 125;
    localparam int POR_CYCLES = POR_TIME_MS * CLK_MHZ * 1000;
endpackage
`default_nettype wire

//--- repeater_config_mode_control.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none
module repeater_config_mode_control
    import repeater_cfg_pkg::*;
#(
    parameter int POR_LIMIT = POR_CYCLES // settle count, shorten in simulation
)(
    input wire logic mclk_i, // core clock
    input wire logic rst_i, // power-on reset, async high
    input wire logic reset_pin_i, // device reset pin, high active
    input wire logic [1:0] interface_mode_strap_i, // resolved strap level
    input wire pin_group_s pins_i, // resolved eq/de-emphasis pins
    input wire logic [1:0] idle_detect_threshold_pin_i, // resolved threshold pin
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb direction
    input wire logic [11:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error on unmapped access
    output lane_cfg_s [NUM_LANES-1:0] lane_cfg_o, // applied lane settings
    output logic [1:0] idle_threshold_o, // applied threshold code
    output mode_e mode_o, // current configuration source
    output logic [3:0] slave_address_o, // bus address from pins
    output logic config_ready_o // configuration applied
);

    // eq pin pair to code; upper pin most significant
    function automatic logic [7:0] eq_lut(input pin_pair_s p);
        logic [3:0] idx;
        idx = {p.high, p.low};
        unique case (idx)
            4'h0: eq_lut = 8'h00;
            4'h1: eq_lut = 8'h01;
            4'h2: eq_lut = 8'h02;
            4'h3: eq_lut = 8'h03;
            4'h4: eq_lut = 8'h07;
            4'h5: eq_lut = 8'h15;
            4'h6: eq_lut = 8'h0B;
            4'h7: eq_lut = 8'h0F;
            4'h8: eq_lut = 8'h55;
            4'h9: eq_lut = 8'h1F;
            4'hA: eq_lut = 8'h2F;
            4'hB: eq_lut = 8'h3F;
            4'hC: eq_lut = 8'hAA;
            4'hD: eq_lut = 8'h7F;
            4'hE: eq_lut = 8'hBF;
            default: eq_lut = 8'hFF;
        endcase
    endfunction

    // de-emphasis pin pair to {swing, deemph}; swing follows the level
    function automatic logic [4:0] dem_lut(input pin_pair_s p);
        logic [3:0] idx;
        idx = {p.high, p.low};
        unique case (idx)
            4'h0: dem_lut = {SWING_0P8, DEEMPH_0DB};
            4'h1: dem_lut = {SWING_0P9, DEEMPH_0DB};
            4'h2: dem_lut = {SWING_0P9, DEEMPH_3P5DB};
            4'h3: dem_lut = {SWING_1P0, DEEMPH_0DB};
            4'h4: dem_lut = {SWING_1P0, DEEMPH_3P5DB};
            4'h5: dem_lut = {SWING_1P0, DEEMPH_6DB};
            4'h6: dem_lut = {SWING_1P1, DEEMPH_0DB};
            4'h7: dem_lut = {SWING_1P1, DEEMPH_3P5DB};
            4'h8: dem_lut = {SWING_1P1, DEEMPH_6DB};
            4'h9: dem_lut = {SWING_1P2, DEEMPH_0DB};
            4'hA: dem_lut = {SWING_1P2, DEEMPH_3P5DB};
            4'hB: dem_lut = {SWING_1P2, DEEMPH_6DB};
            4'hC: dem_lut = {SWING_1P3, DEEMPH_0DB};
            4'hD: dem_lut = {SWING_1P3, DEEMPH_3P5DB};
            4'hE: dem_lut = {SWING_1P3, DEEMPH_6DB};
            default: dem_lut = {SWING_1P3, DEEMPH_9DB};
        endcase
    endfunction

    // build one pin-mode lane setting from a side's pins
    function automatic lane_cfg_s pin_lane(input pin_pair_s e, input pin_pair_s d);
        lane_cfg_s c;
        logic [4:0] sd;
        sd = dem_lut(d);
        c.term_dis = 1'b0;
        c.eq = eq_lut(e);
        c.swing = sd[4:2];
        c.deemph = sd[1:0];
        pin_lane = c;
    endfunction

    // threshold pin level to register code
    function automatic logic [1:0] thr_lut(input logic [1:0] lvl);
        unique case (lvl)
            LVL_0: thr_lut = THR_CODE_LVL0;
            LVL_R: thr_lut = THR_CODE_LVLR;
            LVL_FLOAT: thr_lut = THR_CODE_FLOAT;
            default: thr_lut = THR_CODE_LVL1;
        endcase
    endfunction

    // stored state
    lane_cfg_s [NUM_LANES-1:0] lane_q, lane_d; // per-lane registers
    logic [1:0] thr_q, thr_d; // threshold register
    logic ovr_q, ovr_d; // threshold override latched
    lane_cfg_s [NUM_LANES-1:0] out_q, out_d; // applied lane settings
    logic [1:0] athr_q, athr_d; // applied threshold
    mode_e mode_q, mode_d; // applied mode
    logic [3:0] addr_q, addr_d; // captured address pins
    logic [25:0] por_cnt_q, por_cnt_d; // settle counter
    logic ready_q, ready_d; // settle done
    logic [31:0] rdata_q, rdata_d; // read data register

    // decoded bus and mode terms
    mode_e strap_mode; // mode from the strap alone
    logic apb_setup; // setup phase
    logic apb_wr; // write taking effect
    logic lane_hit; // address in lane window
    logic [2:0] lane_idx; // addressed lane
    logic addr_ok; // mapped address
    logic cfg_clear; // force registers to defaults

    // strap decode; the R level is treated as low
    always_comb
    begin
        unique case (interface_mode_strap_i)
            LVL_1: strap_mode = MODE_SLAVE;
            LVL_FLOAT: strap_mode = MODE_MASTER;
            default: strap_mode = MODE_PIN;
        endcase
    end

    // apb address decode
    always_comb
    begin
        apb_setup = psel_i & ~penable_i;
        apb_wr = psel_i & penable_i & pwrite_i;
        lane_hit = (paddr_i[11:5] == LANE_BASE_OFS[11:5]) && (paddr_i[1:0] == 2'h0);
        lane_idx = paddr_i[4:2];
        addr_ok = lane_hit || (paddr_i == CTRL_OFS) || (paddr_i == STATUS_OFS);
        // strap low always clears; the reset pin clears unless strap high
        cfg_clear = (strap_mode == MODE_PIN)
            || (reset_pin_i && (strap_mode != MODE_SLAVE));
    end

    // register bank next values
    always_comb
    begin
        lane_d = lane_q;
        thr_d = thr_q;
        ovr_d = ovr_q;
        if (cfg_clear)
        begin
            // defaults, override forgotten until next write
            for (int i = 0; i < NUM_LANES; i++)
            begin
                lane_d[i] = lane_cfg_s'(LANE_CFG_RST);
            end
            thr_d = THR_RST;
            ovr_d = 1'b0;
        end
        else if (apb_wr && lane_hit)
        begin
            // each lane has its own full setting, 8-bit eq
            lane_d[lane_idx] = lane_cfg_s'(pwdata_i[13:0]);
        end
        else if (apb_wr && (paddr_i == CTRL_OFS))
        begin
            thr_d = pwdata_i[CTRL_THR_LSB+:2];
            // once set, stays set until a register clear: strap low, or the reset pin unless strap high
            ovr_d = ovr_q | pwdata_i[CTRL_OVR_BIT];
        end
    end

    // applied settings next values
    always_comb
    begin
        out_d = lane_q;
        athr_d = thr_q;
        addr_d = addr_q;
        mode_d = strap_mode;
        if (strap_mode == MODE_PIN)
        begin
            // live decode, follows pin changes every cycle
            for (int i = 0; i < LANES_PER_SIDE; i++)
            begin
                out_d[i] = pin_lane(pins_i.eq_a, pins_i.dem_a);
                out_d[i+LANES_PER_SIDE] = pin_lane(pins_i.eq_b, pins_i.dem_b);
            end
            athr_d = thr_lut(idle_detect_threshold_pin_i);
        end
        else
        begin
            // registers drive lanes straight away
            out_d = lane_q;
            // threshold pin keeps control until overridden
            athr_d = ovr_q ? thr_q : thr_lut(idle_detect_threshold_pin_i);
            // low pin of each selector pair read as an address bit, upper bit of its level
            addr_d = {pins_i.dem_b.low[1], pins_i.dem_a.low[1],
                      pins_i.eq_b.low[1], pins_i.eq_a.low[1]};
        end
    end

    // power-on settle counter
    always_comb
    begin
        por_cnt_d = por_cnt_q;
        ready_d = ready_q;
        if (!ready_q)
        begin
            if (por_cnt_q == 26'(POR_LIMIT - 1))
            begin
                ready_d = 1'b1;
            end
            else
            begin
                por_cnt_d = por_cnt_q + 26'h000_0001;
            end
        end
    end

    // read data captured in the setup phase
    always_comb
    begin
        rdata_d = rdata_q;
        if (apb_setup)
        begin
            rdata_d = 32'h0000_0000;
            if (lane_hit)
            begin
                rdata_d[13:0] = lane_q[lane_idx];
            end
            else if (paddr_i == CTRL_OFS)
            begin
                rdata_d[CTRL_THR_LSB+:2] = thr_q;
                rdata_d[CTRL_OVR_BIT] = ovr_q;
            end
            else if (paddr_i == STATUS_OFS)
            begin
                rdata_d[STAT_MODE_LSB+:3] = mode_q;
                rdata_d[STAT_THR_LSB+:2] = athr_q;
                rdata_d[STAT_ADDR_LSB+:4] = addr_q;
                rdata_d[STAT_READY_BIT] = ready_q;
            end
        end
    end

    // register bank flops
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lane_q <= {NUM_LANES{lane_cfg_s'(LANE_CFG_RST)}};
            thr_q <= THR_RST;
            ovr_q <= 1'b0;
        end
        else
        begin
            lane_q <= lane_d;
            thr_q <= thr_d;
            ovr_q <= ovr_d;
        end
    end

    // applied settings flops
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            out_q <= {NUM_LANES{lane_cfg_s'(LANE_CFG_RST)}};
            athr_q <= THR_RST;
            mode_q <= MODE_PIN;
            addr_q <= 4'h0;
        end
        else
        begin
            out_q <= out_d;
            athr_q <= athr_d;
            mode_q <= mode_d;
            addr_q <= addr_d;
        end
    end

    // settle counter flops
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            por_cnt_q <= 26'h000_0000;
            ready_q <= 1'b0;
        end
        else
        begin
            por_cnt_q <= por_cnt_d;
            ready_q <= ready_d;
        end
    end

    // read data flop
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // outputs; bus answers with no wait state
    assign prdata_o = rdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok;
    assign lane_cfg_o = out_q;
    assign idle_threshold_o = athr_q;
    assign mode_o = mode_q;
    assign slave_address_o = addr_q;
    assign config_ready_o = ready_q;

endmodule
`default_nettype wire

//--- repeater_cfg_ref.svh
// no include guard: the bench and the checker each need their own copy
// equalizer code for a pin pair, index 0..15 as {high,low}
function automatic logic [7:0] eq_ref(input logic [3:0] k);
    return 8'(128'hFFBF_7FAA_3F2F_1F55_0F0B_1507_0302_0100 >> {k, 3'h0});
endfunction
// {swing,deemph} pair for a de-emphasis pin pair
function automatic logic [4:0] dem_ref(input logic [3:0] k);
    return 5'(128'h1716_1514_1211_100E_0D0C_0A09_0805_0400 >> {k, 3'h0});
endfunction
// threshold code for a threshold pin level
function automatic logic [1:0] thr_ref(input logic [1:0] k);
    return 2'(8'hC6 >> {k, 1'h0});
endfunction

//--- repeater_config_mode_control_asserts.sv
`default_nettype none
module repeater_config_mode_control_chk
    import repeater_cfg_pkg::*;
#(
    parameter int POR_LIMIT = POR_CYCLES // settle count
)(
    input wire logic mclk_i, // clock
    input wire logic rst_i, // reset
    input wire logic reset_pin_i, // reset pin
    input wire logic [1:0] interface_mode_strap_i, // strap
    input wire pin_group_s pins_i, // selector pins
    input wire logic [1:0] idle_detect_threshold_pin_i, // threshold pin
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb direction
    input wire logic [11:0] paddr_i, // apb address
    input wire logic [31:0] pwdata_i, // apb write data
    input wire logic [31:0] prdata_o, // apb read data
    input wire logic pready_o, // apb ready
    input wire logic pslverr_o, // apb error
    input wire lane_cfg_s [NUM_LANES-1:0] lane_cfg_o, // lane settings
    input wire logic [1:0] idle_threshold_o, // threshold code
    input wire mode_e mode_o, // mode
    input wire logic [3:0] slave_address_o, // address
    input wire logic config_ready_o // ready
);
    `include "repeater_cfg_ref.svh"
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // pin mode with the reset pin low; the release edge still shows reset values
    logic pin_m;
    assign pin_m = !rst_i && interface_mode_strap_i < 2'h2 && !reset_pin_i;
    // cycles since reset release, saturating
    logic [31:0] por_cnt_q;
    logic [31:0] por_cnt_d;
    always_comb
        por_cnt_d = (&por_cnt_q) ? por_cnt_q : por_cnt_q + 32'h0000_0001;
    always_ff @(posedge mclk_i or posedge rst_i)
        if (rst_i)
            por_cnt_q <= '0;
        else
            por_cnt_q <= por_cnt_d;
    property p_mode_pin;
        interface_mode_strap_i < 2'h2 |=> mode_o == MODE_PIN;
    endproperty
    a_mode_pin: assert property (p_mode_pin) else $error("mode not pin");
    property p_mode_slave;
        !rst_i && interface_mode_strap_i == 2'h3 |=> mode_o == MODE_SLAVE;
    endproperty
    a_mode_slave: assert property (p_mode_slave) else $error("mode not slave");
    property p_mode_master;
        !rst_i && interface_mode_strap_i == 2'h2 |=> mode_o == MODE_MASTER;
    endproperty
    a_mode_master: assert property (p_mode_master) else $error("mode not master");
    property p_eq_a;
        pin_m |=> lane_cfg_o[0].eq == eq_ref($past(pins_i.eq_a));
    endproperty
    a_eq_a: assert property (p_eq_a) else $error("side a eq wrong");
    property p_eq_b;
        pin_m |=> lane_cfg_o[7].eq == eq_ref($past(pins_i.eq_b));
    endproperty
    a_eq_b: assert property (p_eq_b) else $error("side b eq wrong");
    property p_dem_a;
        pin_m |=> {lane_cfg_o[3].swing, lane_cfg_o[3].deemph} == dem_ref($past(pins_i.dem_a));
    endproperty
    a_dem_a: assert property (p_dem_a) else $error("side a swing wrong");
    property p_dem_b;
        pin_m |=> {lane_cfg_o[4].swing, lane_cfg_o[4].deemph} == dem_ref($past(pins_i.dem_b));
    endproperty
    a_dem_b: assert property (p_dem_b) else $error("side b swing wrong");
    property p_thr;
        pin_m |=> idle_threshold_o == thr_ref($past(idle_detect_threshold_pin_i));
    endproperty
    a_thr: assert property (p_thr) else $error("threshold wrong");
    property p_addr;
        !rst_i && interface_mode_strap_i[1] |=> slave_address_o == {$past(pins_i.dem_b.low[1]),
            $past(pins_i.dem_a.low[1]), $past(pins_i.eq_b.low[1]), $past(pins_i.eq_a.low[1])};
    endproperty
    a_addr: assert property (p_addr) else $error("address wrong");
    property p_ready;
        por_cnt_q > 32'(POR_LIMIT) |-> config_ready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("not ready in time");
    c_slave: cover property (mode_o == MODE_SLAVE);
    c_err: cover property (pslverr_o);
    c_ready: cover property ($rose(config_ready_o));
endmodule
bind repeater_config_mode_control repeater_config_mode_control_chk #(.POR_LIMIT(POR_LIMIT)) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .reset_pin_i(reset_pin_i),
    .interface_mode_strap_i(interface_mode_strap_i), .pins_i(pins_i),
    .idle_detect_threshold_pin_i(idle_detect_threshold_pin_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .lane_cfg_o(lane_cfg_o), .idle_threshold_o(idle_threshold_o), .mode_o(mode_o),
    .slave_address_o(slave_address_o), .config_ready_o(config_ready_o));
`default_nettype wire

//--- repeater_apb_host.sv
`default_nettype none
module repeater_apb_host
(
    input wire logic mclk_i, // clock
    input wire logic [31:0] prdata_i, // read data
    input wire logic pready_i, // ready
    input wire logic pslverr_i, // error
    output logic psel_o, // select
    output logic penable_o, // enable
    output logic pwrite_o, // direction
    output logic [11:0] paddr_o, // address
    output logic [31:0] pwdata_o // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idle at time zero
    initial
    begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = '0;
        pwdata_o = '0;
    end
    // one transfer: setup, access until ready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge mclk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        do @(posedge mclk_i); while (pready_i !== 1'b1);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released lines no longer show the old request
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

//--- tb_repeater_config_mode_control.sv
`default_nettype none
module tb_repeater_config_mode_control import repeater_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    `include "repeater_cfg_ref.svh"
    logic mclk = 1'b0; // core clock
    logic rst; // power-on reset
    logic rpin; // reset pin
    logic [1:0] strap; // mode strap level
    pin_group_s pins; // selector pins
    logic [1:0] thr_pin; // threshold pin level
    wire logic psel, penable, pwrite, pready, pslverr; // apb controls
    wire logic [11:0] paddr; // apb address
    wire logic [31:0] pwdata, prdata; // apb data
    lane_cfg_s [NUM_LANES-1:0] lane_cfg; // applied lanes
    logic [1:0] thr; // applied threshold
    mode_e mode; // applied mode
    logic [3:0] addr; // bus address
    logic ready; // configured
    logic [31:0] rdat; // last read data
    logic rerr; // last error flag
    int bad_count = 0;
    int compares = 0;
    always #4 mclk = ~mclk;
    repeater_config_mode_control #(.POR_LIMIT(20)) dut (
        .mclk_i(mclk), .rst_i(rst), .reset_pin_i(rpin), .interface_mode_strap_i(strap),
        .pins_i(pins), .idle_detect_threshold_pin_i(thr_pin), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .lane_cfg_o(lane_cfg),
        .idle_threshold_o(thr), .mode_o(mode), .slave_address_o(addr),
        .config_ready_o(ready));
    repeater_apb_host host (
        .mclk_i(mclk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata));
    // compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // let edges pass, then sample settled outputs
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // distinct in-range lane register value
    function automatic logic [13:0] lv(input int n);
        return {1'(n), 2'(n), 3'(n % 6), 8'(n * 37 + 90)};
    endfunction
    // sweep all sixteen codes on every selector pin pair, both sides apart
    task automatic t_pin();
        for (int k = 0; k < 16; k++)
        begin
            @(posedge mclk);
            strap <= 2'(k % 2);
            pins <= {4'(k), 4'(15 - k), 4'(k), 4'(15 - k)};
            thr_pin <= 2'(k);
            wt(2);
            chk("mode", MODE_PIN, mode);
            chk("eq_a", eq_ref(4'(k)), lane_cfg[0].eq);
            chk("eq_b", eq_ref(4'(15 - k)), lane_cfg[5].eq);
            chk("dem_a", dem_ref(4'(k)), {lane_cfg[2].swing, lane_cfg[2].deemph});
            chk("dem_b", dem_ref(4'(15 - k)), {lane_cfg[6].swing, lane_cfg[6].deemph});
            chk("thr", thr_ref(2'(k)), thr);
        end
    endtask
    // register control of every lane, address pins, unmapped access, master
    task automatic t_slave();
        logic [31:0] st; // expected status word
        @(posedge mclk);
        strap <= 2'h3;
        pins <= {4'h2, 4'h1, 4'h3, 4'h0};
        wt(1);
        chk("slave", MODE_SLAVE, mode);
        chk("addr", 4'h5, addr);
        host.xfer(1'b0, LANE_BASE_OFS + 12'h00C, 32'h0, rdat, rerr);
        chk("lane_rst", LANE_CFG_RST, rdat);
        for (int n = 0; n < NUM_LANES; n++)
        begin
            host.xfer(1'b1, LANE_BASE_OFS + 12'(4 * n), {18'h3_FFFF, lv(n)}, rdat, rerr);
            wt(1);
            chk("lane", lv(n), lane_cfg[n]);
            host.xfer(1'b0, LANE_BASE_OFS + 12'(4 * n), 32'h0, rdat, rerr);
            chk("lane_rd", lv(n), rdat);
        end
        host.xfer(1'b0, 12'h028, 32'h0, rdat, rerr);
        chk("unmapped_err", 1'b1, rerr);
        chk("unmapped_rd", 32'h0, rdat);
        // status: slave mode, threshold pin at level 1, address 5, settled
        st = (32'h0000_0001 << STAT_READY_BIT) | (32'h0000_0005 << STAT_ADDR_LSB);
        st = st | (32'(THR_CODE_LVL1) << STAT_THR_LSB) | 32'(MODE_SLAVE);
        host.xfer(1'b0, STATUS_OFS, 32'h0, rdat, rerr);
        chk("status", st, rdat);
        @(posedge mclk);
        strap <= 2'h2;
        wt(2);
        chk("master", MODE_MASTER, mode);
    endtask
    // reset pin retention, threshold override, clear on strap low
    task automatic t_reset();
        @(posedge mclk);
        strap <= 2'h3;
        rpin <= 1'b1;
        thr_pin <= LVL_0;
        wt(3);
        chk("keep", lv(1), lane_cfg[1]);
        chk("thr_pin", THR_CODE_LVL0, thr);
        @(posedge mclk);
        rpin <= 1'b0;
        host.xfer(1'b1, CTRL_OFS, 32'h0000_0103, rdat, rerr);
        thr_pin <= LVL_R;
        wt(2);
        chk("thr_ovr", 2'h3, thr);
        @(posedge mclk);
        strap <= 2'h0;
        wt(2);
        chk("thr_clr", THR_CODE_LVLR, thr);
        @(posedge mclk);
        strap <= 2'h3;
        host.xfer(1'b0, LANE_BASE_OFS + 12'h004, 32'h0, rdat, rerr);
        chk("cleared", LANE_CFG_RST, rdat);
    endtask
    // counts and verdict, the only end of the run
    task automatic print_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        rst = 1'b1;
        rpin = 1'b0;
        strap = 2'h0;
        pins = '0;
        thr_pin = LVL_FLOAT;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        wt(2);
        chk("ready_early", 1'b0, ready);
        wt(25);
        chk("ready", 1'b1, ready);
        t_pin();
        t_slave();
        t_reset();
        print_verdict();
    end
    // watchdog against a hung handshake
    initial
    begin
        #100us;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
